/* rtl/vaoa_core.sv */
// vector fetch sequencer and basic operand address former
`timescale 1ns/1ps

module vaoa_core
(
    input  wire logic                mclk,        // 10 MHz clock
    input  wire logic                resetn,      // sync reset, low
    // vector request side
    input  wire logic                vec_req,     // take vector, pulse
    input  wire logic                vec_periph,  // request is peripheral
    input  wire logic [5:0]          vec_num,     // interrupt number
    input  wire logic [19:0]         interrupt_table_base, // table base
    output logic                     vec_busy,    // fetch in progress
    output logic                     vec_done,    // handler valid, pulse
    output logic                     vec_err,     // number refused, pulse
    output logic [19:0]              vec_handler, // handler entry addr
    // memory read port for the vector bytes
    output logic                     mem_rd,      // byte read strobe
    output logic [19:0]              mem_addr,    // byte address
    input  wire logic [7:0]          mem_rdata,   // data next cycle
    // operand side
    input  wire logic                op_req,      // form operand, pulse
    input  wire vaoa_pkg::vaoa_opreq_t op_in,     // operand request
    input  wire logic [15:0]         data_reg_zero,   // word reg 0
    input  wire logic [15:0]         data_reg_one,    // word reg 1
    input  wire logic [15:0]         data_reg_two,    // word reg 2
    input  wire logic [15:0]         data_reg_three,  // word reg 3
    input  wire logic [15:0]         address_reg_first,  // addr reg 1
    input  wire logic [15:0]         address_reg_second, // addr reg 2
    output logic                     op_valid,    // result valid, pulse
    output vaoa_pkg::vaoa_opres_t    op_out       // operand result
);

    // ========================================================
    // helpers
    // ========================================================
    // range check of an address against its class
    function automatic logic out_of_class(input logic [19:0] a,
                                          input vaoa_pkg::vaoa_class_t c);
        logic bad;
        bad = 1'b0;
        unique case (c)
            vaoa_pkg::VAOA_C_GEN: bad = (a > vaoa_pkg::GEN_LIMIT);
            vaoa_pkg::VAOA_C_SPC: bad = (a > vaoa_pkg::SPC_LIMIT);
            vaoa_pkg::VAOA_C_BIT: bad = (a > vaoa_pkg::BIT_LIMIT);
            default:              bad = 1'b1;
        endcase
        return bad;
    endfunction : out_of_class

    // ========================================================
    // vector fetch state
    // ========================================================
    typedef enum logic [1:0] {
        VS_IDLE,                                 // waiting
        VS_READ,                                 // issuing byte reads
        VS_LAST                                  // capturing last byte
    } vs_t;

    vs_t          st_q, st_d;                    // sequencer state
    logic [1:0]   idx_q, idx_d;                  // byte index in entry
    logic [19:0]  base_q, base_d;                // entry start address
    logic [19:0]  hand_q, hand_d;                // handler assembly
    logic         rdp_q, rdp_d;                  // read issued last cycle
    logic [1:0]   ridx_q, ridx_d;                // index of that read
    logic         done_q, done_d;                // done pulse
    logic         err_q, err_d;                  // refusal pulse
    logic         rd_q, rd_d;                    // read strobe
    logic [19:0]  addr_q, addr_d;                // read address
    logic         num_ok;                        // request number legal

    // peripherals may only use 0..31, software 0..63
    assign num_ok = vec_periph ? (vec_num <= vaoa_pkg::PERIPH_MAX)
                               : (vec_num <= vaoa_pkg::SWI_MAX);

    // next-state for the vector fetch
    always_comb
    begin
        st_d   = st_q;
        idx_d  = idx_q;
        base_d = base_q;
        hand_d = hand_q;
        done_d = 1'b0;
        err_d  = 1'b0;
        rd_d   = 1'b0;
        addr_d = addr_q;
        rdp_d  = rd_q;
        // the read now on the bus was issued with the previous index,
        // so its data must land one slot behind idx_q (wraps 0 to 3)
        ridx_d = idx_q - 2'd1;
        // capture the byte read one cycle earlier, little endian
        if (rdp_q)
        begin
            unique case (ridx_q)
                2'd0: hand_d[7:0]   = mem_rdata;
                2'd1: hand_d[15:8]  = mem_rdata;
                2'd2: hand_d[19:16] = mem_rdata[3:0];
                2'd3: hand_d        = hand_d;  // top byte beyond 20 bits
            endcase
        end
        unique case (st_q)
            VS_IDLE:
            begin
                if (vec_req)
                begin
                    if (num_ok)
                    begin
                        // entry lies in the 256-byte window
                        base_d = interrupt_table_base
                               + {12'h000, vec_num,
                                  {vaoa_pkg::VEC_ENTRY_SHIFT{1'b0}}};
                        idx_d  = 2'd0;
                        hand_d = 20'h0_0000;
                        st_d   = VS_READ;
                    end
                    else
                    begin
                        err_d = 1'b1;  // refused number
                    end
                end
            end
            VS_READ:
            begin
                // four consecutive byte reads of the entry
                rd_d   = 1'b1;
                addr_d = base_q + {18'h0_0000, idx_q};
                idx_d  = idx_q + 2'd1;
                if (idx_q == vaoa_pkg::LAST_BYTE)
                    st_d = VS_LAST;
            end
            VS_LAST:
            begin
                // wait for last read data then report
                if (!rd_q && !rdp_q)
                begin
                    done_d = 1'b1;
                    st_d   = VS_IDLE;
                end
            end
            default: st_d = VS_IDLE;
        endcase
    end

    // register the vector fetch state
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            st_q   <= VS_IDLE;
            idx_q  <= 2'd0;
            base_q <= 20'h0_0000;
            hand_q <= 20'h0_0000;
            rdp_q  <= 1'b0;
            ridx_q <= 2'd0;
            done_q <= 1'b0;
            err_q  <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= 20'h0_0000;
        end
        else
        begin
            st_q   <= st_d;
            idx_q  <= idx_d;
            base_q <= base_d;
            hand_q <= hand_d;
            rdp_q  <= rdp_d;
            ridx_q <= ridx_d;
            done_q <= done_d;
            err_q  <= err_d;
            rd_q   <= rd_d;
            addr_q <= addr_d;
        end
    end

    // busy mirrors a registered state flag
    logic busy_q, busy_d;                        // busy flag
    assign busy_d = (st_d != VS_IDLE);

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            busy_q <= 1'b0;
        else
            busy_q <= busy_d;
    end

    assign vec_busy    = busy_q;
    assign vec_done    = done_q;
    assign vec_err     = err_q;
    assign vec_handler = hand_q;
    assign mem_rd      = rd_q;
    assign mem_addr    = addr_q;

    // ========================================================
    // operand former, one cycle latency
    // ========================================================
    logic                  opv_q, opv_d;         // valid pulse
    vaoa_pkg::vaoa_opres_t res_q, res_d;         // registered result

    // compute operand from mode
    always_comb
    begin
        logic [15:0] rv;
        rv    = 16'h0000;
        opv_d = op_req;
        res_d = res_q;
        if (op_req)
        begin
            res_d = '0;
            unique case (op_in.mode)
                vaoa_pkg::VAOA_M_IMM:
                begin
                    // constant, low byte at b7..b0
                    unique case (op_in.width)
                        vaoa_pkg::VAOA_W8:
                            res_d.data = {12'h000, op_in.field[7:0]};
                        vaoa_pkg::VAOA_W16:
                            res_d.data = {4'h0, op_in.field[15:0]};
                        default:
                            res_d.data = op_in.field;
                    endcase
                end
                vaoa_pkg::VAOA_M_REG:
                begin
                    // named register; halves of regs 0 and 1
                    unique case (op_in.rsel)
                        vaoa_pkg::VAOA_R_D0:  rv = data_reg_zero;
                        vaoa_pkg::VAOA_R_D1:  rv = data_reg_one;
                        vaoa_pkg::VAOA_R_D2:  rv = data_reg_two;
                        vaoa_pkg::VAOA_R_D3:  rv = data_reg_three;
                        vaoa_pkg::VAOA_R_AF:  rv = address_reg_first;
                        vaoa_pkg::VAOA_R_AS:  rv = address_reg_second;
                        vaoa_pkg::VAOA_R_D0L: rv = {8'h00, data_reg_zero[7:0]};
                        vaoa_pkg::VAOA_R_D0H: rv = {8'h00, data_reg_zero[15:8]};
                        vaoa_pkg::VAOA_R_D1L: rv = {8'h00, data_reg_one[7:0]};
                        vaoa_pkg::VAOA_R_D1H: rv = {8'h00, data_reg_one[15:8]};
                        default:              rv = 16'h0000;
                    endcase
                    res_d.data = {4'h0, rv};
                end
                vaoa_pkg::VAOA_M_ABS:
                begin
                    // 16-bit field taken as address
                    res_d.is_addr = 1'b1;
                    res_d.ea      = {4'h0, op_in.field[15:0]};
                end
                vaoa_pkg::VAOA_M_IND:
                begin
                    // selected address register as address
                    res_d.is_addr = 1'b1;
                    res_d.ea = (op_in.rsel == vaoa_pkg::VAOA_R_AS)
                             ? {4'h0, address_reg_second}
                             : {4'h0, address_reg_first};
                end
                default: res_d = '0;
            endcase
            // flag an address outside its class
            if (res_d.is_addr)
                res_d.range_err = out_of_class(res_d.ea, op_in.cls);
        end
    end

    // register the operand result
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            opv_q <= 1'b0;
            res_q <= '0;
        end
        else
        begin
            opv_q <= opv_d;
            res_q <= res_d;
        end
    end

    assign op_valid = opv_q;
    assign op_out   = res_q;

    // ========================================================
    // checks
    // ========================================================
    property p_vec_refuse;
        @(posedge mclk) disable iff (!resetn)
        (st_q == VS_IDLE && vec_req && vec_periph && vec_num > 6'h1F)
            |=> vec_err && !vec_busy;
    endproperty
    a_vec_refuse: assert property (p_vec_refuse)
        else $error("peripheral number above 31 not refused");

    property p_vec_first_addr;
        logic [19:0] b;
        @(posedge mclk) disable iff (!resetn)
        (st_q == VS_IDLE && vec_req && num_ok,
         b = interrupt_table_base + {12'h000, vec_num, 2'b00})
            |-> ##2 (mem_rd && mem_addr == b);
    endproperty
    a_vec_first_addr: assert property (p_vec_first_addr)
        else $error("vector fetch address wrong");

    sequence s_four_reads;
        mem_rd [*4];
    endsequence
    property p_vec_four;
        @(posedge mclk) disable iff (!resetn)
        (st_q == VS_IDLE && vec_req && num_ok) |-> ##2 s_four_reads
            ##1 !mem_rd;
    endproperty
    a_vec_four: assert property (p_vec_four)
        else $error("entry not read as four bytes");

    property p_vec_done;
        @(posedge mclk) disable iff (!resetn)
        (st_q == VS_IDLE && vec_req && num_ok) |-> ##[6:8] vec_done;
    endproperty
    a_vec_done: assert property (p_vec_done)
        else $error("vector fetch did not finish");

    property p_swi_ok;
        @(posedge mclk) disable iff (!resetn)
        (st_q == VS_IDLE && vec_req && !vec_periph) |=> !vec_err;
    endproperty
    a_swi_ok: assert property (p_swi_ok)
        else $error("software number refused");

    property p_abs;
        @(posedge mclk) disable iff (!resetn)
        (op_req && op_in.mode == vaoa_pkg::VAOA_M_ABS)
            |=> op_valid && op_out.ea == {4'h0, $past(op_in.field[15:0])};
    endproperty
    a_abs: assert property (p_abs)
        else $error("absolute address wrong");

    property p_ind;
        @(posedge mclk) disable iff (!resetn)
        (op_req && op_in.mode == vaoa_pkg::VAOA_M_IND
         && op_in.rsel == vaoa_pkg::VAOA_R_AS)
            |=> op_out.ea[15:0] == $past(address_reg_second);
    endproperty
    a_ind: assert property (p_ind)
        else $error("indirect address wrong");

    property p_imm8;
        @(posedge mclk) disable iff (!resetn)
        (op_req && op_in.mode == vaoa_pkg::VAOA_M_IMM
         && op_in.width == vaoa_pkg::VAOA_W8)
            |=> op_out.data == {12'h000, $past(op_in.field[7:0])};
    endproperty
    a_imm8: assert property (p_imm8)
        else $error("byte immediate wrong");

    property p_hbyte;
        @(posedge mclk) disable iff (!resetn)
        (op_req && op_in.mode == vaoa_pkg::VAOA_M_REG
         && op_in.rsel == vaoa_pkg::VAOA_R_D0H)
            |=> op_out.data[7:0] == $past(data_reg_zero[15:8]);
    endproperty
    a_hbyte: assert property (p_hbyte)
        else $error("high byte half wrong");

    // general class addresses never leave the 16-bit space
    property p_gen_range;
        @(posedge mclk) disable iff (!resetn)
        (op_req && op_in.cls == vaoa_pkg::VAOA_C_GEN
         && (op_in.mode == vaoa_pkg::VAOA_M_ABS
             || op_in.mode == vaoa_pkg::VAOA_M_IND))
            |=> op_out.is_addr && op_out.ea[19:16] == 4'h0
                && !op_out.range_err;
    endproperty
    a_gen_range: assert property (p_gen_range)
        else $error("general class address outside 16 bits");

endmodule : vaoa_core

/* rtl/vaoa_pkg.sv */
// package: constants and carrier types for vector and operand addressing
package vaoa_pkg;

    // ========================================================
    // address widths and ranges
    // ========================================================
    localparam int          ADDR_W         = 20;          // full space
    localparam int          GEN_W          = 16;          // general class
    localparam logic [19:0] GEN_LIMIT      = 20'h0_FFFF;  // general top
    localparam logic [19:0] SPC_LIMIT      = 20'hF_FFFF;  // special top
    localparam logic [19:0] BIT_LIMIT      = 20'h0_0FFF;  // bit class top

    // ========================================================
    // vector table layout
    // ========================================================
    localparam int          VEC_TABLE_BYTES = 256;        // table size
    localparam int          VEC_ENTRY_BYTES = 4;          // per entry
    localparam int          VEC_ENTRY_SHIFT = 2;          // log2 entry
    localparam logic [5:0]  SWI_MAX         = 6'h3F;      // number 63
    localparam logic [5:0]  PERIPH_MAX      = 6'h1F;      // number 31
    localparam logic [1:0]  LAST_BYTE       = 2'h3;       // 4th byte idx

    // ========================================================
    // operand modes and classes
    // ========================================================
    typedef enum logic [2:0] {
        VAOA_M_IMM,                                      // immediate
        VAOA_M_REG,                                      // register direct
        VAOA_M_ABS,                                      // absolute 16
        VAOA_M_IND                                       // addr reg indirect
    } vaoa_mode_t;

    typedef enum logic [1:0] {
        VAOA_C_GEN,                                      // general class
        VAOA_C_SPC,                                      // special class
        VAOA_C_BIT                                       // bit class
    } vaoa_class_t;

    typedef enum logic [1:0] {
        VAOA_W8,                                         // byte
        VAOA_W16,                                        // word
        VAOA_W20                                         // 20-bit
    } vaoa_width_t;

    // register selector: 0..5 word regs, 6..9 byte halves
    typedef enum logic [3:0] {
        VAOA_R_D0, VAOA_R_D1, VAOA_R_D2, VAOA_R_D3,
        VAOA_R_AF, VAOA_R_AS,
        VAOA_R_D0L, VAOA_R_D0H, VAOA_R_D1L, VAOA_R_D1H
    } vaoa_reg_t;

    // operand request from decode
    typedef struct packed {
        vaoa_mode_t  mode;                               // addressing mode
        vaoa_class_t cls;                                // addressing class
        vaoa_width_t width;                              // immediate width
        vaoa_reg_t   rsel;                               // register select
        logic [19:0] field;                              // imm or abs field
    } vaoa_opreq_t;

    // operand answer
    typedef struct packed {
        logic        is_addr;                            // ea valid, not data
        logic [19:0] ea;                                 // effective address
        logic [19:0] data;                               // immediate/reg val
        logic        range_err;                          // outside class
    } vaoa_opres_t;

endpackage : vaoa_pkg

/* verif/vaoa_mem_model.sv */
// memory model: byte store that holds the relocatable vector table
`timescale 1ns/1ps

// ============================================================
// memory bus partner
// ============================================================
module vaoa_mem_model
(
    input  wire logic        mclk,      // system clock
    input  wire logic        mem_rd,    // byte read strobe
    input  wire logic [19:0] mem_addr,  // byte address
    output logic      [7:0]  mem_rdata  // byte answer, next cycle
);
    logic [7:0] mem [int];              // sparse store, bench fills it

    initial mem_rdata = 8'h00;

    // answer one cycle after the strobe; between reads the byte flips
    // every cycle so a stale value can never pass for a fresh one
    always @(posedge mclk)
    begin
        if (mem_rd)
        begin
            // software placed the handler entry bytes here
            if (mem.exists(int'(mem_addr)))
                mem_rdata <= mem[int'(mem_addr)];
            else
                mem_rdata <= 8'hA5;     // unfilled cell, arbitrary
        end
        else
            mem_rdata <= ~mem_rdata;    // released bus, no hold
    end
endmodule : vaoa_mem_model

/* verif/vector_and_operand_addressing_bench.sv */
// testbench: vector fetch and operand address forming
`timescale 1ns/1ps

// ============================================================
// bench top
// ============================================================
module vector_and_operand_addressing_bench;
    logic                  mclk = 1'b0;        // 10 MHz clock
    logic                  resetn = 1'b0;      // sync reset, low
    logic                  vec_req = 1'b0;     // vector request
    logic                  vec_periph = 1'b0;  // peripheral source
    logic [5:0]            vec_num = 6'h00;    // interrupt number
    logic [19:0]           interrupt_table_base = 20'h0_0000; // base
    logic                  vec_busy, vec_done, vec_err; // status
    logic [19:0]           vec_handler;        // fetched handler
    logic                  mem_rd;             // byte read strobe
    logic [19:0]           mem_addr;           // byte address
    logic [7:0]            mem_rdata;          // byte answer
    logic                  op_req = 1'b0;      // operand request
    vaoa_pkg::vaoa_opreq_t op_in = '0;         // operand fields
    logic [15:0]           regs [6] = '{16'hA1B2, 16'hC3D4, 16'h5566,
                                        16'h7788, 16'h9ABC, 16'hDEF0};
    logic                  op_valid;           // operand pulse
    vaoa_pkg::vaoa_opres_t op_out;             // operand result
    int                    n_fail = 0;         // mismatches
    int                    n_tests = 0;        // comparisons

    always #50 mclk = ~mclk;

    vaoa_core dut (.mclk(mclk), .resetn(resetn), .vec_req(vec_req),
        .vec_periph(vec_periph), .vec_num(vec_num),
        .interrupt_table_base(interrupt_table_base),
        .vec_busy(vec_busy), .vec_done(vec_done), .vec_err(vec_err),
        .vec_handler(vec_handler), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .op_req(op_req), .op_in(op_in),
        .data_reg_zero(regs[0]), .data_reg_one(regs[1]),
        .data_reg_two(regs[2]), .data_reg_three(regs[3]),
        .address_reg_first(regs[4]), .address_reg_second(regs[5]),
        .op_valid(op_valid), .op_out(op_out));

    vaoa_mem_model u_mem (.mclk(mclk), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata));

    // ========================================================
    // shared tasks
    // ========================================================
    task check(input logic [19:0] seen, input logic [19:0] exp,
               input string what);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check

    task tally_and_finish;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // vector fetch: entry bytes placed first, then the strobes are
    // traced address by address until done or a refusal
    task run_vec(input logic [19:0] base, input logic [5:0] num,
                 input logic periph, input logic [19:0] h,
                 input logic refuse);
        logic [19:0] ent;
        int          k;
        logic        got_err;
        logic        got_done;
        ent = base + 20'(num) * 20'h0_0004;
        u_mem.mem[int'(ent)] = h[7:0];
        u_mem.mem[int'(ent) + 1] = h[15:8];
        u_mem.mem[int'(ent) + 2] = {4'hE, h[19:16]};
        u_mem.mem[int'(ent) + 3] = 8'h9C;      // top byte, dropped
        @(negedge mclk);
        vec_req = 1'b1;
        vec_num = num;
        vec_periph = periph;
        interrupt_table_base = base;
        @(negedge mclk);
        vec_req = 1'b0;
        k = 0;
        got_err = 1'b0;
        got_done = 1'b0;
        for (int i = 0; i < 12 && !got_done && !got_err; i++)
        begin
            if (mem_rd === 1'b1)
            begin
                check(mem_addr, ent + 20'(k), "fetch address");
                k++;
            end
            if (vec_done === 1'b1) got_done = 1'b1;
            if (vec_err === 1'b1) got_err = 1'b1;
            if (!got_done && !got_err) @(negedge mclk);
        end
        check(20'(got_err), 20'(refuse), "refusal flag");
        check(20'(k), refuse ? 20'h0_0000 : 20'h0_0004,
              "byte count");
        if (!refuse)
            check(vec_handler, h, "handler address");
        @(negedge mclk);
        check(20'(vec_busy), 20'h0_0000, "busy after end");
    endtask : run_vec

    // one operand request, waits for its valid pulse
    task run_op(input vaoa_pkg::vaoa_mode_t m,
                input vaoa_pkg::vaoa_class_t c,
                input vaoa_pkg::vaoa_width_t w,
                input vaoa_pkg::vaoa_reg_t r, input logic [19:0] f);
        @(negedge mclk);
        op_req = 1'b1;
        op_in = '{mode: m, cls: c, width: w, rsel: r, field: f};
        @(negedge mclk);
        op_req = 1'b0;
        for (int i = 0; i < 3 && op_valid !== 1'b1; i++)
            @(negedge mclk);
        check(20'(op_valid), 20'h0_0001, "operand valid");
    endtask : run_op

    // ========================================================
    // main sequence
    // ========================================================
    initial
    begin
        logic [19:0] fld [3];
        fld = '{20'h5_F123, 20'h0_0FFF, 20'h0_1000};
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        check(20'(vec_busy), 20'h0_0000, "busy at reset");
        // top entry of a table, then peripheral edges and a refusal
        run_vec(20'h1_2300, 6'h3F, 1'b0, 20'h3_4567, 1'b0);
        run_vec(20'h0_0400, 6'h00, 1'b1, 20'hB_0011, 1'b0);
        run_vec(20'h0_0400, 6'h1F, 1'b1, 20'h2_7654, 1'b0);
        run_vec(20'h0_0400, 6'h20, 1'b1, 20'h0_0000, 1'b1);
        run_vec(20'hF_FF00, 6'h20, 1'b0, 20'h9_8765, 1'b0);
        // immediate constants of each width
        for (int w = 0; w < 3; w++)
        begin
            run_op(vaoa_pkg::VAOA_M_IMM, vaoa_pkg::VAOA_C_GEN,
                   vaoa_pkg::vaoa_width_t'(w), vaoa_pkg::VAOA_R_D0,
                   20'hA_BCDE);
            check(op_out.data, w == 0 ? 20'h0_00DE : w == 1 ?
                  20'h0_BCDE : 20'hA_BCDE, "immediate");
            check(20'(op_out.is_addr), 20'h0_0000, "imm is data");
        end
        // every register and byte half
        for (int r = 0; r < 10; r++)
        begin
            run_op(vaoa_pkg::VAOA_M_REG, vaoa_pkg::VAOA_C_GEN,
                   vaoa_pkg::VAOA_W16, vaoa_pkg::vaoa_reg_t'(r),
                   20'h0_0000);
            if (r < 6)
                check(op_out.data, {4'h0, regs[r]}, "word reg");
            else if (r[0] == 1'b0)
                check(20'(op_out.data[7:0]), 20'(regs[(r - 6) / 2][7:0]),
                      "low half");
            else
                check(20'(op_out.data[7:0]), 20'(regs[(r - 6) / 2][15:8]),
                      "high half");
        end
        // absolute field against each class limit
        for (int c = 0; c < 3; c++)
            for (int j = 0; j < 3; j++)
            begin
                run_op(vaoa_pkg::VAOA_M_ABS, vaoa_pkg::vaoa_class_t'(c),
                       vaoa_pkg::VAOA_W16, vaoa_pkg::VAOA_R_D0, fld[j]);
                check(op_out.ea, {4'h0, fld[j][15:0]}, "absolute");
                check(20'(op_out.is_addr), 20'h0_0001,
                      "abs is addr");
                check(20'(op_out.range_err), 20'(c == 2 && j != 1),
                      "class range");
            end
        // both address registers, general and bit class
        for (int a = 0; a < 2; a++)
            for (int c = 0; c < 3; c += 2)
            begin
                run_op(vaoa_pkg::VAOA_M_IND, vaoa_pkg::vaoa_class_t'(c),
                       vaoa_pkg::VAOA_W16, vaoa_pkg::vaoa_reg_t'(4 + a),
                       20'h0_0000);
                check(op_out.ea, {4'h0, regs[4 + a]}, "indirect");
                check(20'(op_out.range_err), 20'(c == 2),
                      "ind range");
            end
        tally_and_finish();
    end

    // watchdog: the run needs about 100 cycles, limit is 4000
    initial
    begin
        #400_000;
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : vector_and_operand_addressing_bench
